// *** hw/exception_lowpower_pkg.sv ***
package exception_lowpower_pkg;

    // Register byte offsets on the APB side.
    localparam logic [7:0] BREAK_STATUS_OFFSET = 8'h00;
    localparam logic [7:0] BREAK_FLAG_CONTROL_OFFSET = 8'h04;
    localparam logic [7:0] CONFIG_OFFSET = 8'h08;
    localparam logic [7:0] STATE_OFFSET = 8'h0c;

    // Field positions.
    localparam int BREAK_WAKE_FLAG_BIT = 0;
    localparam int BREAK_CLEAR_ENABLE_BIT = 0;
    localparam int SHORT_RECOVERY_BIT = 0;
    localparam int WATCHDOG_DISABLE_BIT = 1;
    localparam int STATE_MODE_LSB = 0;
    localparam int STATE_BREAK_BIT = 4;
    localparam int STATE_LATCHED_BIT = 5;
    localparam int STATE_VECTOR_LSB = 8;

    // Reset values.
    localparam logic CONFIG_SHORT_RECOVERY_RESET = 1'b0;
    localparam logic CONFIG_WATCHDOG_DISABLE_RESET = 1'b0;
    localparam logic BREAK_CLEAR_ENABLE_RESET = 1'b0;

    // Stop recovery lengths in crystal clock cycles.
    localparam int LONG_RECOVERY_CYCLES = 4096;
    localparam int SHORT_RECOVERY_CYCLES = 32;
    localparam int RECOVERY_COUNT_WIDTH = 13;

    // Vector selection codes handed to the core.
    localparam logic [7:0] VECTOR_NONE = 8'h00;
    localparam logic [7:0] VECTOR_SOFTWARE = 8'h01;
    localparam logic [7:0] VECTOR_HW_BASE = 8'h02;

    // Program counter adjustment pushed on entry.
    localparam logic [1:0] PC_ADJUST_HW = 2'h1;
    localparam logic [1:0] PC_ADJUST_SOFTWARE = 2'h0;

    typedef enum logic [2:0] {
        MODE_RUN = 3'b000,
        MODE_STACK = 3'b001,
        MODE_WAIT = 3'b010,
        MODE_STOP = 3'b011,
        MODE_RECOVER = 3'b100
    } mode_t;

    // Entry sequence, one bus cycle per step: five pushes, then two vector fetches.
    typedef enum logic [2:0] {
        STEP_PC_LOW = 3'b000,
        STEP_PC_HIGH = 3'b001,
        STEP_INDEX_X = 3'b010,
        STEP_ACCUM = 3'b011,
        STEP_COND_CODES = 3'b100,
        STEP_VECTOR_HIGH = 3'b101,
        STEP_VECTOR_LOW = 3'b110
    } stack_step_t;

endpackage

// *** hw/exception_lowpower_control.sv ***
`timescale 1ns/1ps
`default_nettype none

module exception_lowpower_control #(
    parameter int NUM_SOURCES = 8,
    parameter int LONG_RECOVERY = exception_lowpower_pkg::LONG_RECOVERY_CYCLES,
    parameter int SHORT_RECOVERY = exception_lowpower_pkg::SHORT_RECOVERY_CYCLES
) (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic [NUM_SOURCES-1:0] irq_request_in,
    input wire logic [NUM_SOURCES-1:0] irq_enable_in,
    input wire logic cond_mask_in,
    input wire logic instr_done_in,
    input wire logic software_interrupt_op_in,
    input wire logic return_from_interrupt_op_in,
    input wire logic wait_op_in,
    input wire logic stop_op_in,
    input wire logic break_request_in,
    input wire logic reset_source_in,
    input wire logic crystal_clock_in,
    output logic stacking_out,
    output logic [2:0] stack_step_out,
    output logic [1:0] pc_adjust_out,
    output logic [7:0] vector_code_out,
    output logic set_mask_out,
    output logic clear_mask_out,
    output logic break_state_out,
    output logic flag_clear_allow_out,
    output logic core_clock_enable_out,
    output logic periph_clock_enable_out,
    output logic main_clock_enable_out,
    output logic crystal_clock_enable_out,
    output logic sys_counter_reset_out,
    output logic watchdog_run_out
);

    localparam int IDX_W = (NUM_SOURCES > 1) ? $clog2(NUM_SOURCES) : 1;
    localparam int CW = exception_lowpower_pkg::RECOVERY_COUNT_WIDTH;

    initial begin
        if (NUM_SOURCES < 1 || NUM_SOURCES > 200) begin
            $error("NUM_SOURCES out of range");
        end
        if (LONG_RECOVERY < 1 || SHORT_RECOVERY < 1 || LONG_RECOVERY >= (1 << CW)) begin
            $error("Recovery lengths out of range");
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State.

    exception_lowpower_pkg::mode_t mode_q, mode_d;
    logic [2:0] step_q, step_d;
    logic latched_q, latched_d;
    logic [7:0] vector_q, vector_d;
    logic [1:0] adjust_q, adjust_d;
    logic break_state_q, break_state_d;
    logic wake_break_q, wake_break_d;
    logic set_mask_q, set_mask_d;
    logic clear_mask_q, clear_mask_d;
    logic [CW-1:0] recover_cnt_q, recover_cnt_d;
    logic break_wake_flag_q, break_wake_flag_d;
    logic break_clear_enable_q;
    logic short_recovery_q;
    logic watchdog_disable_q;
    logic [31:0] prdata_q;
    logic xtal_s1_q, xtal_s2_q, xtal_s3_q, xtal_level_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Crystal clock input: three stages, an edge counts once stages two and three agree.

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            xtal_s1_q <= 1'b0;
            xtal_s2_q <= 1'b0;
            xtal_s3_q <= 1'b0;
            xtal_level_q <= 1'b0;
        end else begin
            xtal_s1_q <= crystal_clock_in;
            xtal_s2_q <= xtal_s1_q;
            xtal_s3_q <= xtal_s2_q;
            if (xtal_s2_q == xtal_s3_q) begin
                xtal_level_q <= xtal_s3_q;
            end
        end
    end

    // The system counter steps on the falling crystal edge.
    wire xtal_tick = xtal_level_q && !xtal_s2_q && !xtal_s3_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Arbitration: the lowest index has the highest priority.

    wire [NUM_SOURCES-1:0] pending = irq_request_in & irq_enable_in;
    wire any_pending = |pending;
    logic [IDX_W-1:0] winner;

    always_comb begin
        winner = '0;
        for (int i = NUM_SOURCES - 1; i >= 0; i--) begin
            if (pending[i]) begin
                winner = IDX_W'(i);
            end
        end
    end

    wire [7:0] winner_code = exception_lowpower_pkg::VECTOR_HW_BASE + 8'(winner);

    // Reset sources bypass arbitration entirely.
    wire reset_hit = rst_in || reset_source_in;
    // A return counts as a boundary, so a waiting request beats the next instruction.
    wire boundary = instr_done_in || return_from_interrupt_op_in;
    wire hw_take = boundary && !cond_mask_in && any_pending;

    wire [CW-1:0] recover_limit = short_recovery_q ? CW'(SHORT_RECOVERY) :
        CW'(LONG_RECOVERY);

    ////////////////////////////////////////////////////////////////////////////////
    // Sequencer.

    always_comb begin
        mode_d = mode_q;
        step_d = step_q;
        latched_d = latched_q;
        vector_d = vector_q;
        adjust_d = adjust_q;
        break_state_d = break_state_q;
        wake_break_d = 1'b0;
        set_mask_d = 1'b0;
        clear_mask_d = 1'b0;
        recover_cnt_d = recover_cnt_q;
        if (return_from_interrupt_op_in) begin
            break_state_d = 1'b0;
        end
        case (mode_q)
            exception_lowpower_pkg::MODE_RUN: begin
                if (break_request_in && boundary) begin
                    latched_d = 1'b1;
                    vector_d = exception_lowpower_pkg::VECTOR_SOFTWARE;
                    adjust_d = exception_lowpower_pkg::PC_ADJUST_SOFTWARE;
                    break_state_d = 1'b1;
                    mode_d = exception_lowpower_pkg::MODE_STACK;
                    step_d = exception_lowpower_pkg::STEP_PC_LOW;
                end else if (software_interrupt_op_in) begin
                    latched_d = 1'b1;
                    vector_d = exception_lowpower_pkg::VECTOR_SOFTWARE;
                    adjust_d = exception_lowpower_pkg::PC_ADJUST_SOFTWARE;
                    mode_d = exception_lowpower_pkg::MODE_STACK;
                    step_d = exception_lowpower_pkg::STEP_PC_LOW;
                end else if (hw_take) begin
                    latched_d = 1'b1;
                    vector_d = winner_code;
                    adjust_d = exception_lowpower_pkg::PC_ADJUST_HW;
                    mode_d = exception_lowpower_pkg::MODE_STACK;
                    step_d = exception_lowpower_pkg::STEP_PC_LOW;
                end else if (wait_op_in) begin
                    clear_mask_d = 1'b1;
                    mode_d = exception_lowpower_pkg::MODE_WAIT;
                end else if (stop_op_in) begin
                    clear_mask_d = 1'b1;
                    mode_d = exception_lowpower_pkg::MODE_STOP;
                end
            end
            exception_lowpower_pkg::MODE_STACK: begin
                // The latched vector is frozen here; later requests wait their turn.
                if (step_q == exception_lowpower_pkg::STEP_COND_CODES) begin
                    set_mask_d = 1'b1;
                end
                if (step_q == exception_lowpower_pkg::STEP_VECTOR_LOW) begin
                    latched_d = 1'b0;
                    mode_d = exception_lowpower_pkg::MODE_RUN;
                end else begin
                    step_d = step_q + 3'h1;
                end
            end
            exception_lowpower_pkg::MODE_WAIT: begin
                if (break_request_in) begin
                    wake_break_d = 1'b1;
                    latched_d = 1'b1;
                    vector_d = exception_lowpower_pkg::VECTOR_SOFTWARE;
                    adjust_d = exception_lowpower_pkg::PC_ADJUST_SOFTWARE;
                    break_state_d = 1'b1;
                    mode_d = exception_lowpower_pkg::MODE_STACK;
                    step_d = exception_lowpower_pkg::STEP_PC_LOW;
                end else if (any_pending) begin
                    latched_d = 1'b1;
                    vector_d = winner_code;
                    adjust_d = exception_lowpower_pkg::PC_ADJUST_HW;
                    mode_d = exception_lowpower_pkg::MODE_STACK;
                    step_d = exception_lowpower_pkg::STEP_PC_LOW;
                end
            end
            exception_lowpower_pkg::MODE_STOP: begin
                recover_cnt_d = '0;
                if (break_request_in) begin
                    wake_break_d = 1'b1;
                    break_state_d = 1'b1;
                    mode_d = exception_lowpower_pkg::MODE_RECOVER;
                end else if (any_pending) begin
                    mode_d = exception_lowpower_pkg::MODE_RECOVER;
                end
            end
            exception_lowpower_pkg::MODE_RECOVER: begin
                if (xtal_tick) begin
                    recover_cnt_d = recover_cnt_q + CW'(1);
                end
                if (recover_cnt_q >= recover_limit) begin
                    // The winner is chosen when stacking actually starts.
                    latched_d = 1'b1;
                    vector_d = break_state_q ? exception_lowpower_pkg::VECTOR_SOFTWARE :
                        winner_code;
                    adjust_d = break_state_q ? exception_lowpower_pkg::PC_ADJUST_SOFTWARE :
                        exception_lowpower_pkg::PC_ADJUST_HW;
                    mode_d = exception_lowpower_pkg::MODE_STACK;
                    step_d = exception_lowpower_pkg::STEP_PC_LOW;
                end
            end
            default: begin
                mode_d = exception_lowpower_pkg::MODE_RUN;
            end
        endcase
        if (reset_hit) begin
            mode_d = exception_lowpower_pkg::MODE_RUN;
            step_d = exception_lowpower_pkg::STEP_PC_LOW;
            latched_d = 1'b0;
            vector_d = exception_lowpower_pkg::VECTOR_NONE;
            adjust_d = exception_lowpower_pkg::PC_ADJUST_SOFTWARE;
            break_state_d = 1'b0;
            wake_break_d = 1'b0;
            set_mask_d = 1'b0;
            clear_mask_d = 1'b0;
            recover_cnt_d = '0;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        mode_q <= mode_d;
        step_q <= step_d;
        latched_q <= latched_d;
        vector_q <= vector_d;
        adjust_q <= adjust_d;
        break_state_q <= break_state_d;
        wake_break_q <= 1'b0;
        set_mask_q <= set_mask_d;
        clear_mask_q <= clear_mask_d;
        recover_cnt_q <= recover_cnt_d;
        if (!rst_in) begin
            wake_break_q <= wake_break_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // APB slave: zero wait states, read data captured in the setup cycle.

    wire setup_phase = psel_in && !penable_in;
    wire access_phase = psel_in && penable_in;
    wire hit_status = paddr_in == exception_lowpower_pkg::BREAK_STATUS_OFFSET;
    wire hit_control = paddr_in == exception_lowpower_pkg::BREAK_FLAG_CONTROL_OFFSET;
    wire hit_config = paddr_in == exception_lowpower_pkg::CONFIG_OFFSET;
    wire hit_state = paddr_in == exception_lowpower_pkg::STATE_OFFSET;
    wire mapped = hit_status || hit_control || hit_config || hit_state;
    wire wr_en = access_phase && pwrite_in;
    wire wr_status = wr_en && hit_status;
    wire wr_control = wr_en && hit_control;
    wire wr_config = wr_en && hit_config;

    logic [31:0] read_mux;
    always_comb begin
        read_mux = 32'h0000_0000;
        if (hit_status) begin
            read_mux[exception_lowpower_pkg::BREAK_WAKE_FLAG_BIT] = break_wake_flag_q;
        end
        if (hit_control) begin
            read_mux[exception_lowpower_pkg::BREAK_CLEAR_ENABLE_BIT] = break_clear_enable_q;
        end
        if (hit_config) begin
            read_mux[exception_lowpower_pkg::SHORT_RECOVERY_BIT] = short_recovery_q;
            read_mux[exception_lowpower_pkg::WATCHDOG_DISABLE_BIT] = watchdog_disable_q;
        end
        if (hit_state) begin
            read_mux[exception_lowpower_pkg::STATE_MODE_LSB +: 3] = mode_q;
            read_mux[exception_lowpower_pkg::STATE_BREAK_BIT] = break_state_q;
            read_mux[exception_lowpower_pkg::STATE_LATCHED_BIT] = latched_q;
            read_mux[exception_lowpower_pkg::STATE_VECTOR_LSB +: 8] = vector_q;
        end
    end

    // A break wake sets the flag even in the cycle software writes zero to it.
    always_comb begin
        break_wake_flag_d = break_wake_flag_q;
        if (wr_status && !pwdata_in[exception_lowpower_pkg::BREAK_WAKE_FLAG_BIT]) begin
            break_wake_flag_d = 1'b0;
        end
        if (wake_break_q) begin
            break_wake_flag_d = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            break_wake_flag_q <= 1'b0;
            break_clear_enable_q <= exception_lowpower_pkg::BREAK_CLEAR_ENABLE_RESET;
            short_recovery_q <= exception_lowpower_pkg::CONFIG_SHORT_RECOVERY_RESET;
            watchdog_disable_q <= exception_lowpower_pkg::CONFIG_WATCHDOG_DISABLE_RESET;
            prdata_q <= 32'h0000_0000;
        end else begin
            break_wake_flag_q <= break_wake_flag_d;
            if (wr_control) begin
                break_clear_enable_q <=
                    pwdata_in[exception_lowpower_pkg::BREAK_CLEAR_ENABLE_BIT];
            end
            if (wr_config) begin
                short_recovery_q <= pwdata_in[exception_lowpower_pkg::SHORT_RECOVERY_BIT];
                watchdog_disable_q <= pwdata_in[exception_lowpower_pkg::WATCHDOG_DISABLE_BIT];
            end
            if (setup_phase && !pwrite_in) begin
                prdata_q <= read_mux;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs.

    wire in_wait = mode_q == exception_lowpower_pkg::MODE_WAIT;
    wire in_stop = mode_q == exception_lowpower_pkg::MODE_STOP;
    wire in_recover = mode_q == exception_lowpower_pkg::MODE_RECOVER;

    assign prdata_out = prdata_q;
    assign pready_out = 1'b1;
    assign pslverr_out = access_phase && !mapped;
    assign stacking_out = mode_q == exception_lowpower_pkg::MODE_STACK;
    assign stack_step_out = step_q;
    assign pc_adjust_out = adjust_q;
    assign vector_code_out = vector_q;
    assign set_mask_out = set_mask_q;
    assign clear_mask_out = clear_mask_q;
    assign break_state_out = break_state_q;
    // One enable covers two-step clears too, so a pre-break first step waits out break.
    assign flag_clear_allow_out = !break_state_q || break_clear_enable_q;
    assign core_clock_enable_out = !(in_wait || in_stop || in_recover);
    assign periph_clock_enable_out = !(in_stop || in_recover);
    assign main_clock_enable_out = !(in_stop || in_recover);
    assign crystal_clock_enable_out = !in_stop;
    assign sys_counter_reset_out = in_stop;
    assign watchdog_run_out = !watchdog_disable_q;

endmodule

`default_nettype wire

// *** sim/exception_lowpower_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module exception_lowpower_props (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic instr_done_in,
    input wire logic software_interrupt_op_in,
    input wire logic return_from_interrupt_op_in,
    input wire logic stacking_out,
    input wire logic [2:0] stack_step_out,
    input wire logic [1:0] pc_adjust_out,
    input wire logic [7:0] vector_code_out,
    input wire logic set_mask_out,
    input wire logic break_state_out,
    input wire logic flag_clear_allow_out,
    input wire logic core_clock_enable_out,
    input wire logic main_clock_enable_out,
    input wire logic crystal_clock_enable_out,
    input wire logic sys_counter_reset_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    ////////////////////////////////////////////////////////////
    // A software interrupt op and a wake from a low-power mode are the only entries without a boundary pulse.
    boundary_only_a: assert property ($rose(stacking_out) |-> stack_step_out == 3'h0 &&
        $past(instr_done_in || software_interrupt_op_in || return_from_interrupt_op_in ||
        !core_clock_enable_out)) else $error("entry off boundary");
    push_order_a: assert property (stacking_out && stack_step_out != 3'h6
        |=> stacking_out && stack_step_out == $past(stack_step_out) + 3'h1) else $error("order");
    mask_after_push_a: assert property (set_mask_out == (stacking_out && stack_step_out == 3'h5))
        else $error("mask timing");
    latch_hold_a: assert property (stacking_out && $past(stacking_out)
        |-> $stable(vector_code_out)) else $error("latch moved");
    entry_adjust_a: assert property (stacking_out |-> pc_adjust_out ==
        ((vector_code_out >= exception_lowpower_pkg::VECTOR_HW_BASE) ?
        exception_lowpower_pkg::PC_ADJUST_HW : exception_lowpower_pkg::PC_ADJUST_SOFTWARE))
        else $error("pc adjust");
    break_vector_a: assert property (stacking_out && break_state_out
        |-> vector_code_out == exception_lowpower_pkg::VECTOR_SOFTWARE) else $error("break vector");
    flag_guard_a: assert property (!break_state_out |-> flag_clear_allow_out)
        else $error("flag guard");
    stop_gating_a: assert property (sys_counter_reset_out |-> !main_clock_enable_out &&
        !crystal_clock_enable_out && !core_clock_enable_out) else $error("stop gating");
    cover property (stacking_out && vector_code_out == exception_lowpower_pkg::VECTOR_SOFTWARE);
    cover property (sys_counter_reset_out);
    cover property (break_state_out && flag_clear_allow_out);
endmodule
`default_nettype wire

// *** sim/core_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module core_model (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic set_mask_in,
    input wire logic clear_mask_in,
    input wire logic restore_in,
    input wire logic crystal_enable_in,
    input wire logic stacking_in,
    input wire logic [2:0] stack_step_in,
    output logic cond_mask_out,
    output logic crystal_clock_out,
    output logic [7:0] push_count_out
);
    logic [1:0] div_q;
    // The oscillator freezes while gated, so no tick can leak into stop.
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            cond_mask_out <= 1'b0;
            crystal_clock_out <= 1'b1;
            div_q <= 2'h0;
            push_count_out <= 8'h00;
        end else begin
            if (set_mask_in) begin
                cond_mask_out <= 1'b1;
            end else if (clear_mask_in || restore_in) begin
                cond_mask_out <= 1'b0;
            end
            if (stacking_in && stack_step_in <= 3'h4) begin
                push_count_out <= push_count_out + 8'h01;
            end
            if (crystal_enable_in) begin
                div_q <= div_q + 2'h1;
                if (div_q == 2'h3) crystal_clock_out <= !crystal_clock_out;
            end
        end
    end
endmodule
`default_nettype wire

// *** sim/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int LONG_SIM = 8;
    localparam int SHORT_SIM = 4;
    localparam logic [7:0] VNO = exception_lowpower_pkg::VECTOR_NONE;
    localparam logic [7:0] VSW = exception_lowpower_pkg::VECTOR_SOFTWARE;
    localparam logic [7:0] VHW = exception_lowpower_pkg::VECTOR_HW_BASE;
    localparam logic [1:0] AHW = exception_lowpower_pkg::PC_ADJUST_HW;
    localparam logic [1:0] ASW = exception_lowpower_pkg::PC_ADJUST_SOFTWARE;
    logic clk_sys_in, rst_in, psel, penable, pwrite, pready, pslverr, err, brk, rst_src, restore;
    logic cond_mask, xtal, stacking, set_mask, clear_mask, brk_state, flag_allow, core_en;
    logic periph_en, main_en, xtal_en, cnt_rst, wdog_run;
    logic [7:0] paddr, irq_req, irq_en, vector, pushes, push_base;
    logic [31:0] pwdata, prdata, rd;
    logic [4:0] op_q;
    logic [2:0] step;
    logic [1:0] adjust;
    int failures, samples_checked, ticks, tick_seen, i, lim;
    exception_lowpower_control #(.NUM_SOURCES(8), .LONG_RECOVERY(LONG_SIM),
        .SHORT_RECOVERY(SHORT_SIM)) u_dut (
        .clk_sys_in, .rst_in, .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .irq_request_in(irq_req),
        .irq_enable_in(irq_en), .cond_mask_in(cond_mask), .instr_done_in(op_q[0]),
        .software_interrupt_op_in(op_q[1]), .return_from_interrupt_op_in(op_q[2]),
        .wait_op_in(op_q[3]), .stop_op_in(op_q[4]), .break_request_in(brk),
        .reset_source_in(rst_src), .crystal_clock_in(xtal), .stacking_out(stacking),
        .stack_step_out(step), .pc_adjust_out(adjust), .vector_code_out(vector),
        .set_mask_out(set_mask), .clear_mask_out(clear_mask), .break_state_out(brk_state),
        .flag_clear_allow_out(flag_allow), .core_clock_enable_out(core_en),
        .periph_clock_enable_out(periph_en), .main_clock_enable_out(main_en),
        .crystal_clock_enable_out(xtal_en), .sys_counter_reset_out(cnt_rst),
        .watchdog_run_out(wdog_run));
    core_model u_core (.clk_sys_in, .rst_in, .set_mask_in(set_mask),
        .clear_mask_in(clear_mask), .restore_in(restore), .crystal_enable_in(xtal_en),
        .stacking_in(stacking), .stack_step_in(step), .cond_mask_out(cond_mask),
        .crystal_clock_out(xtal), .push_count_out(pushes));
    ////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
        int n;
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, addr, data};
        @(posedge clk_sys_in);
        penable <= 1'b1;
        @(posedge clk_sys_in);
        for (n = 0; n < 50 && pready !== 1'b1; n++) @(posedge clk_sys_in);
        if (n == 50) failures++;
        if (n == 50) complete_run();
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
        @(posedge clk_sys_in);
    endtask
    task automatic pulse(input logic [4:0] v);
        @(posedge clk_sys_in);
        op_q <= v;
        @(posedge clk_sys_in);
        op_q <= 5'h00;
    endtask
    task automatic do_return();
        @(posedge clk_sys_in);
        restore <= 1'b1;
        @(posedge clk_sys_in);
        restore <= 1'b0;
        pulse(5'h04);
    endtask
    task automatic entry(input logic [7:0] exp_vec, input logic [1:0] exp_adj);
        int n;
        push_base = pushes;
        for (n = 0; n < 300 && stacking !== 1'b1; n++) @(posedge clk_sys_in);
        tick_seen = ticks;
        if (exp_vec === VNO) begin
            check("stacking", 32'(stacking), 32'h0);
        end else begin
            if (n == 300) failures++;
            if (n == 300) complete_run();
            check("vector", 32'(vector), 32'(exp_vec));
            check("adjust", 32'(adjust), 32'(exp_adj));
            for (n = 0; n < 20 && stacking === 1'b1; n++) @(posedge clk_sys_in);
            check("pushes", 32'(pushes - push_base), 32'h5);
        end
    endtask
    always @(negedge xtal) ticks++;
    initial begin
        clk_sys_in = 1'b0;
        forever #5 clk_sys_in = ~clk_sys_in;
    end
    initial begin
        {failures, samples_checked, ticks} = '0;
        {psel, penable, pwrite, brk, rst_src, restore, rst_in} = 7'h01;
        {paddr, irq_req, irq_en, op_q, pwdata} = '0;
        repeat (6) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        for (i = 0; i < 5; i++) begin
            apb(1'b0, 8'(i * 4), 32'h0);
            check("reset read", rd, 32'h0);
            check("slave error", 32'(err), 32'(i == 4));
        end
        check("watchdog run", 32'(wdog_run), 32'h1);
        irq_en <= 8'h0a;
        irq_req <= 8'h0b;
        entry(VNO, ASW);
        pulse(5'h01);
        entry(VHW + 8'h01, AHW);
        pulse(5'h01);
        entry(VNO, ASW);
        irq_req <= 8'h09;
        do_return();
        entry(VHW + 8'h03, AHW);
        pulse(5'h02);
        entry(VSW, ASW);
        irq_req <= 8'h00;
        brk <= 1'b1;
        pulse(5'h01);
        entry(VSW, ASW);
        check("flag clear", 32'({brk_state, flag_allow}), 32'h2);
        apb(1'b1, 8'h04, 32'h1);
        check("flag clear", 32'(flag_allow), 32'h1);
        brk <= 1'b0;
        pulse(5'h04);
        apb(1'b1, 8'h04, 32'h0);
        check("break state", 32'({brk_state, flag_allow}), 32'h1);
        pulse(5'h08);
        repeat (2) @(posedge clk_sys_in);
        check("wait clocks", 32'({core_en, periph_en, cond_mask, wdog_run}), 32'h5);
        @(posedge clk_sys_in);
        irq_req <= 8'h08;
        entry(VHW + 8'h03, AHW);
        apb(1'b1, 8'h08, 32'h2);
        check("watchdog run", 32'(wdog_run), 32'h0);
        irq_req <= 8'h00;
        pulse(5'h08);
        @(posedge clk_sys_in);
        brk <= 1'b1;
        entry(VSW, ASW);
        brk <= 1'b0;
        apb(1'b0, 8'h00, 32'h0);
        check("break wake flag", rd, 32'h1);
        apb(1'b1, 8'h00, 32'h0);
        apb(1'b0, 8'h00, 32'h0);
        check("break wake flag", rd, 32'h0);
        do_return();
        for (i = 0; i < 2; i++) begin
            lim = (i == 1) ? SHORT_SIM : LONG_SIM;
            apb(1'b1, 8'h08, 32'(i));
            pulse(5'h10);
            @(posedge clk_sys_in);
            check("stop gating", 32'({cnt_rst, main_en, xtal_en, core_en}), 32'h8);
            @(posedge clk_sys_in);
            irq_req <= 8'h08;
            ticks = 0;
            entry(VHW + 8'h03, AHW);
            check("recovery ticks", 32'(tick_seen >= lim && tick_seen <= lim + 1), 32'h1);
            irq_req <= 8'h00;
        end
        pulse(5'h08);
        @(posedge clk_sys_in);
        {irq_req, rst_src} <= {8'h08, 1'b1};
        @(posedge clk_sys_in);
        {irq_req, rst_src} <= {8'h00, 1'b0};
        entry(VNO, ASW);
        check("core clock", 32'(core_en), 32'h1);
        complete_run();
    end
endmodule
bind exception_lowpower_control exception_lowpower_props u_props (.clk_sys_in, .rst_in,
    .instr_done_in, .software_interrupt_op_in, .return_from_interrupt_op_in, .stacking_out,
    .stack_step_out, .pc_adjust_out, .vector_code_out, .set_mask_out, .break_state_out,
    .flag_clear_allow_out, .core_clock_enable_out, .main_clock_enable_out,
    .crystal_clock_enable_out, .sys_counter_reset_out);
`default_nettype wire
